// ==== rtl/pps_stage.sv ====
// Purpose: protection stage with blocking, events and general settings
// What the document requires
// [RULE1] latch-reset command clears all latches, then reads back idle
// [RULE2] one of ten objects chosen, first by default; push-button leds follow it
// [RULE3] device mode on/blocked/test/test-blocked/off, on by default, gated by permit
// [RULE4] fault-reset logic input clears the latest fault register
// [RULE5] latch-reset logic input clears latches like the back button
// [RULE6] phase-rotation input low means A-B-C, high means A-C-B; the code also selects A-C-B whenever the cfg phase bit is set
// [RULE7] magnitude continuously compared with pick-up level, over or under
// [RULE8] release only past 97 percent of the pick-up level
// [RULE9] blocking input sampled at the start of every program cycle
// [RULE10] pick-up without blocking raises start
// [RULE11] pick-up with blocking raises blocked, no timing or trip
// [RULE12] blocking during start drops start and runs release behaviour
// [RULE13] blocking raises display event and time-stamped log with values, type
// [RULE14] outside source asserts blocking 5 ms before operating delay ends
// [RULE15] measurement recorder off by default, runs only when enabled
// [RULE16] instant operation trips in the same cycle as start
// [RULE17] blocked stage re-evaluates each cycle and starts once unblocked
// Purpose: top of the stage
// Assumes: cycle_tick marks the start of each program cycle
// Notes:   only instant tripping; delayed curves live elsewhere
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_stage (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [`PPS_AW-1:0]     addr,
    input  wire logic [`PPS_DW-1:0]     wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [`PPS_DW-1:0]     rdata,
    input  wire logic                   cycle_tick,
    input  wire logic [`PPS_MW-1:0]     meas,
    input  wire logic                   blk_in,
    input  wire logic [`PPS_FT_W-1:0]   fault_type,
    input  wire logic [`PPS_OBJ_N-1:0]  obj_closed,
    input  wire logic [`PPS_OBJ_N-1:0]  obj_open,
    input  wire logic                   li_reset_latch,
    input  wire logic                   li_reset_fault,
    input  wire logic                   li_phase_rot,
    output logic                        start,
    output logic                        blocked,
    output logic                        trip,
    output logic                        release_evt,
    output logic                        blk_event,
    output logic                        trip_latched,
    output logic                        latch_clear,
    output logic                        led_close,
    output logic                        led_open,
    output logic                        phase_acb,
    output logic      [`PPS_MODE_W-1:0] dev_mode,
    output logic                        rec_run,
    output logic                        irq
);
    pps_pick_if pk ();

    logic [`PPS_CFG_W-1:0]  cfg;
    pps_pkg::pps_mode_t     mode;
    logic [`PPS_MW-1:0]     pick_level;
    logic [`PPS_IRQ_W-1:0]  irq_st;
    logic [`PPS_IRQ_W-1:0]  irq_msk;
    logic [`PPS_DW-1:0]     tstamp;
    logic [`PPS_DW-1:0]     evt_ts;
    logic [`PPS_MW-1:0]     evt_meas;
    logic [`PPS_FT_W-1:0]   evt_type;
    logic [`PPS_MW-1:0]     start_meas;
    logic [`PPS_MW-1:0]     fault_mag;
    logic                   fault_valid;
    logic                   blk_s;
    logic                   eval;
    pps_pkg::pps_stage_t    state;
    pps_pkg::pps_stage_t    next_state;

    // register decode
    wire        wr_cfg   = wr && addr == `PPS_ADDR_CFG;
    wire        wr_mode  = wr && addr == `PPS_ADDR_MODE;
    wire        wr_cmd   = wr && addr == `PPS_ADDR_CMD;
    wire        wr_pick  = wr && addr == `PPS_ADDR_PICK;
    wire        wr_ist   = wr && addr == `PPS_ADDR_IRQ_ST;
    wire        wr_imsk  = wr && addr == `PPS_ADDR_IRQ_MSK;
    wire        mode_ok  = cfg[`PPS_CFG_MODE_OK];
    wire        obj_ok   = wdata[`PPS_CFG_OBJ_MSB:`PPS_CFG_OBJ_LSB]
                           <= `PPS_OBJ_LAST;
    wire        mode_val = wdata[`PPS_MODE_W-1:0] <= `PPS_MODE_LAST;
    wire [`PPS_OBJ_W-1:0] obj_sel = cfg[`PPS_CFG_OBJ_MSB:`PPS_CFG_OBJ_LSB];

    // either path clears the same latches
    wire do_latch_clr = (wr_cmd && wdata[`PPS_CMD_LATCH])            // [RULE1]
                        || li_reset_latch;                           // [RULE5]
    wire do_fault_clr = (wr_cmd && wdata[`PPS_CMD_FAULT])
                        || li_reset_fault;                           // [RULE4]

    wire active  = mode != pps_pkg::PPS_MODE_OFF;                    // [RULE3]
    wire blk_eff = blk_s || mode == pps_pkg::PPS_MODE_BLOCKED
                   || mode == pps_pkg::PPS_MODE_TEST_BLK;
    wire instant = cfg[`PPS_CFG_INSTANT];

    always_comb begin
        next_state = state;
        if (eval) begin
            if (!active || !pk.picked) begin
                next_state = pps_pkg::PPS_ST_IDLE;
            end else if (blk_eff) begin
                next_state = pps_pkg::PPS_ST_BLOCKED;                // [RULE11]
            end else begin
                next_state = pps_pkg::PPS_ST_START;        // [RULE10] [RULE17]
            end
        end
    end

    wire next_start   = next_state == pps_pkg::PPS_ST_START;
    wire next_blocked = next_state == pps_pkg::PPS_ST_BLOCKED;
    // blocking never trips; only instant mode trips here
    wire next_trip    = next_start && instant;                       // [RULE16]
    wire start_rise   = next_start && !start;
    wire trip_rise    = next_trip && !trip;
    wire blk_rise     = next_blocked && !blocked;                    // [RULE13]
    wire from_idle    = state == pps_pkg::PPS_ST_IDLE
                        && next_state != pps_pkg::PPS_ST_IDLE;
    // blocking out of start also counts as a release
    wire next_release = start && !next_start;                        // [RULE12]

    wire [`PPS_IRQ_W-1:0] irq_set = {trip_rise, blk_rise, start_rise};
    // a new event beats a write-one clear in the same cycle
    wire [`PPS_IRQ_W-1:0] next_irq_st =
        (irq_st & ~(wr_ist ? wdata[`PPS_IRQ_W-1:0] : '0)) | irq_set;
    wire [`PPS_IRQ_W-1:0] next_irq_msk =
        wr_imsk ? wdata[`PPS_IRQ_W-1:0] : irq_msk;

    wire [`PPS_DW-1:0] stat_word = {24'h0, fault_valid, trip_latched,
                                    pk.picked, blk_s, trip, blocked, start,
                                    active};
    wire [`PPS_DW-1:0] mode_word = mode_ok ? `PPS_DW'(mode) : '0;   // [RULE3]
    logic [`PPS_DW-1:0] rd_mux;
    always_comb begin
        unique case (addr)
            `PPS_ADDR_CFG:      rd_mux = `PPS_DW'(cfg);
            `PPS_ADDR_MODE:     rd_mux = mode_word;
            `PPS_ADDR_PICK:     rd_mux = `PPS_DW'(pick_level);
            `PPS_ADDR_STAT:     rd_mux = stat_word;
            `PPS_ADDR_IRQ_ST:   rd_mux = `PPS_DW'(irq_st);
            `PPS_ADDR_IRQ_MSK:  rd_mux = `PPS_DW'(irq_msk);
            `PPS_ADDR_EVT_TS:   rd_mux = evt_ts;
            `PPS_ADDR_EVT_INFO: rd_mux = {13'h0, evt_type, evt_meas};
            `PPS_ADDR_FAULT:    rd_mux = `PPS_DW'(fault_mag);
            `PPS_ADDR_TSTAMP:   rd_mux = tstamp;
            // command bits are self-clearing and read as idle
            default:            rd_mux = '0;                         // [RULE1]
        endcase
    end

    // pick-up element sees the live measurement on each tick
    assign pk.set_level = pick_level;
    assign pk.meas      = meas;
    assign pk.under     = cfg[`PPS_CFG_UNDER];
    assign pk.tick      = cycle_tick;

    pps_pickup u_pick (
        .clk  (clk),
        .rstn (rstn),
        .p    (pk.elem)
    );

    // settings
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg        <= `PPS_CFG_RST;                      // [RULE2] [RULE15]
            mode       <= pps_pkg::PPS_MODE_ON;                      // [RULE3]
            pick_level <= `PPS_PICK_RST;
            irq_msk    <= '0;
        end else begin
            if (wr_cfg) begin
                cfg <= obj_ok ? wdata[`PPS_CFG_W-1:0]
                              : {wdata[`PPS_CFG_W-1:`PPS_OBJ_W], obj_sel};
            end
            if (wr_mode && mode_ok && mode_val) begin                // [RULE3]
                mode <= pps_pkg::pps_mode_t'(wdata[`PPS_MODE_W-1:0]);
            end
            if (wr_pick) begin
                pick_level <= wdata[`PPS_MW-1:0];
            end
            irq_msk <= next_irq_msk;
        end
    end

    // program cycle: blocking sampled with the tick, stage judged after
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blk_s  <= 1'b0;
            eval   <= 1'b0;
            tstamp <= '0;
        end else begin
            if (cycle_tick) begin
                blk_s <= blk_in;                                     // [RULE9]
            end
            eval   <= cycle_tick;
            tstamp <= tstamp + `PPS_DW'(cycle_tick);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state       <= pps_pkg::PPS_ST_IDLE;
            start       <= 1'b0;
            blocked     <= 1'b0;
            trip        <= 1'b0;
            release_evt <= 1'b0;
            blk_event   <= 1'b0;
        end else begin
            state       <= next_state;                              // [RULE17]
            start       <= next_start;                    // [RULE10] [RULE12]
            blocked     <= next_blocked;                             // [RULE11]
            trip        <= next_trip;                                // [RULE16]
            release_evt <= next_release;                             // [RULE12]
            blk_event   <= blk_rise;                                 // [RULE13]
        end
    end

    // startup values, event log, latches and fault register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_meas   <= '0;
            evt_ts       <= '0;
            evt_meas     <= '0;
            evt_type     <= '0;
            trip_latched <= 1'b0;
            latch_clear  <= 1'b0;
            fault_mag    <= '0;
            fault_valid  <= 1'b0;
            irq_st       <= '0;
        end else begin
            if (from_idle) begin
                start_meas <= meas;
            end
            if (blk_rise) begin                                      // [RULE13]
                evt_ts   <= tstamp;
                evt_meas <= from_idle ? meas : start_meas;
                evt_type <= fault_type;
            end
            // a fresh trip beats a clear in the same cycle
            trip_latched <= trip_rise || (trip_latched && !do_latch_clr);
            latch_clear  <= do_latch_clr;                   // [RULE1] [RULE5]
            if (trip_rise) begin
                fault_mag <= meas;
            end
            fault_valid <= trip_rise || (fault_valid && !do_fault_clr);
            irq_st      <= next_irq_st;
        end
    end

    // outputs toward panel, matrix and recorder
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata     <= '0;
            led_close <= 1'b0;
            led_open  <= 1'b0;
            phase_acb <= 1'b0;
            dev_mode  <= '0;
            rec_run   <= 1'b0;
            irq       <= 1'b0;
        end else begin
            rdata     <= rd ? rd_mux : '0;
            led_close <= obj_closed[obj_sel];                        // [RULE2]
            led_open  <= obj_open[obj_sel];                          // [RULE2]
            // logic input and setting: either one selects A-C-B
            phase_acb <= li_phase_rot || cfg[`PPS_CFG_PHASE];        // [RULE6]
            dev_mode  <= mode;
            rec_run   <= cfg[`PPS_CFG_REC];                          // [RULE15]
            irq       <= |(next_irq_st & next_irq_msk);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_start_blk_excl: assert property (!(start && blocked)) // [RULE11]
        else $error("start and blocked high together");
    a_unblock_start: assert property (
        eval && active && pk.picked && !blk_eff |=> start) // [RULE17]
        else $error("no start after blocking cleared");
    a_blk_drops_start: assert property (
        start && eval && active && pk.picked && blk_eff
        |=> !start && blocked ##0 release_evt) // [RULE12]
        else $error("blocking did not release start");
    a_start_when_free: assert property (
        $rose(start) |-> $past(!blk_eff && pk.picked)) // [RULE10]
        else $error("start rose while blocked or not picked");
    a_trip_instant: assert property (
        $rose(start) && $past(instant) |-> trip) // [RULE16]
        else $error("instant trip not with start");
    a_blocked_no_trip: assert property (blocked |-> !trip) // [RULE11]
        else $error("trip while blocked");
    a_blk_event_log: assert property (
        $rose(blocked) |-> blk_event && evt_ts == $past(tstamp)
        ##1 irq_st[`PPS_IRQ_BLOCK]) // [RULE13]
        else $error("blocking event not logged");
    a_blk_sample: assert property (
        cycle_tick ##1 !cycle_tick |-> blk_s == $past(blk_in)) // [RULE9]
        else $error("blocking not sampled on the tick");
    a_latch_clear: assert property (
        li_reset_latch && !trip_rise |=> latch_clear && !trip_latched)
        // [RULE5]
        else $error("logic input did not clear latches");
    a_cmd_idle: assert property (
        rd && addr == `PPS_ADDR_CMD |=> rdata == '0) // [RULE1]
        else $error("latch command not read back idle");
    a_cmd_clear: assert property (
        wr_cmd && wdata[`PPS_CMD_LATCH] && !trip_rise
        |=> latch_clear && !trip_latched) // [RULE1]
        else $error("latch command kept the latches");
    a_fault_clear: assert property (
        li_reset_fault && !trip_rise |=> !fault_valid) // [RULE4]
        else $error("fault register not cleared");
    a_phase_sel: assert property (
        ##1 !cfg[`PPS_CFG_PHASE] && $past(!cfg[`PPS_CFG_PHASE])
        |-> phase_acb == $past(li_phase_rot)) // [RULE6]
        else $error("phase order not following the input");
    a_rec_gate: assert property (rec_run |-> $past(cfg[`PPS_CFG_REC]))
        // [RULE15]
        else $error("recorder running while disabled");
    a_led_follow: assert property (
        ##1 $stable(cfg) |-> led_close == $past(obj_closed[obj_sel]))
        // [RULE2]
        else $error("close led not following chosen object");
    a_mode_hidden: assert property (
        rd && addr == `PPS_ADDR_MODE && !mode_ok |=> rdata == '0) // [RULE3]
        else $error("mode visible without permit");

    c_start:      cover property ($rose(start));
    c_blocked:    cover property ($rose(blocked));
    c_start_blk:  cover property (start ##1 blocked);
    c_unblock:    cover property (blocked ##1 start);
endmodule

// ==== rtl/pps_defines.svh ====
// Purpose: constants of the protection pick-up stage
// Assumes: 8-bit byte address, 32-bit register words
// Notes:   definitions only
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_AW            8
`define PPS_DW            32
`define PPS_MW            16

`define PPS_ADDR_CFG      8'h00
`define PPS_ADDR_MODE     8'h04
`define PPS_ADDR_CMD      8'h08
`define PPS_ADDR_PICK     8'h0c
`define PPS_ADDR_STAT     8'h10
`define PPS_ADDR_IRQ_ST   8'h14
`define PPS_ADDR_IRQ_MSK  8'h18
`define PPS_ADDR_EVT_TS   8'h1c
`define PPS_ADDR_EVT_INFO 8'h20
`define PPS_ADDR_FAULT    8'h24
`define PPS_ADDR_TSTAMP   8'h28

`define PPS_CFG_OBJ_LSB   0
`define PPS_CFG_OBJ_MSB   3
`define PPS_CFG_PHASE     4
`define PPS_CFG_REC       5
`define PPS_CFG_UNDER     6
`define PPS_CFG_INSTANT   7
`define PPS_CFG_MODE_OK   8
`define PPS_CFG_W         9
`define PPS_CFG_RST       9'h080

`define PPS_CMD_LATCH     0
`define PPS_CMD_FAULT     1

`define PPS_OBJ_W         4
`define PPS_OBJ_N         10
`define PPS_OBJ_LAST      4'h9
`define PPS_MODE_W        3
`define PPS_MODE_LAST     3'h4
`define PPS_FT_W          3

`define PPS_IRQ_START     0
`define PPS_IRQ_BLOCK     1
`define PPS_IRQ_TRIP      2
`define PPS_IRQ_W         3

`define PPS_PICK_RST      16'h0100
`define PPS_RATIO_PCT     7'h61
`define PPS_FULL_PCT      7'h64
`define PPS_PROD_W        23

`endif

// ==== rtl/pps_pkg.sv ====
// Purpose: types shared by the pick-up stage files
// Assumes: pps_defines.svh for widths
// Notes:   no constants beyond the enumerations
`include "pps_defines.svh"
package pps_pkg;
    typedef enum logic [`PPS_MODE_W-1:0] {
        PPS_MODE_ON,
        PPS_MODE_BLOCKED,
        PPS_MODE_TEST,
        PPS_MODE_TEST_BLK,
        PPS_MODE_OFF
    } pps_mode_t;

    typedef enum logic [1:0] {
        PPS_ST_IDLE,
        PPS_ST_START,
        PPS_ST_BLOCKED
    } pps_stage_t;
endpackage

// ==== rtl/pps_pick_if.sv ====
// Purpose: link between the stage control and its pick-up element
// Assumes: one clock domain
// Notes:   picked changes only on a program cycle tick
`timescale 1ns/1ps
`include "pps_defines.svh"
interface pps_pick_if;
    logic [`PPS_MW-1:0] set_level;
    logic [`PPS_MW-1:0] meas;
    logic               under;
    logic               tick;
    logic               picked;

    modport stage (output set_level, output meas, output under,
                   output tick, input picked);
    modport elem  (input set_level, input meas, input under,
                   input tick, output picked);
endinterface

// ==== rtl/pps_pickup.sv ====
// Purpose: pick-up element with fixed reset ratio
// Assumes: set level and measurement in the same unit
// Notes:   ratio taken by cross multiplication, no divider
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_pickup (
    input  wire logic clk,
    input  wire logic rstn,
    pps_pick_if.elem  p
);
    logic [`PPS_PROD_W-1:0] meas_full;
    logic [`PPS_PROD_W-1:0] set_full;
    logic [`PPS_PROD_W-1:0] meas_ratio;
    logic [`PPS_PROD_W-1:0] set_ratio;
    logic                   over_pick;
    logic                   over_hold;
    logic                   under_pick;
    logic                   under_hold;
    logic                   next_picked;
    logic                   picked;

    // scaled compare stands in for the ratio meas / set
    assign meas_full  = `PPS_PROD_W'(p.meas * `PPS_FULL_PCT);          // [RULE7]
    assign set_full   = `PPS_PROD_W'(p.set_level * `PPS_FULL_PCT);
    assign meas_ratio = `PPS_PROD_W'(p.meas * `PPS_RATIO_PCT);
    assign set_ratio  = `PPS_PROD_W'(p.set_level * `PPS_RATIO_PCT);

    assign over_pick  = meas_full > set_full;                        // [RULE7]
    assign over_hold  = meas_full >= set_ratio;                      // [RULE8]
    assign under_pick = meas_full < set_full;                        // [RULE7]
    // undervalue mirrors the band: release once meas*0.97 reaches set
    assign under_hold = meas_ratio < set_full;                       // [RULE8]

    assign next_picked = p.under ? (picked ? under_hold : under_pick)
                                 : (picked ? over_hold  : over_pick);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            picked <= 1'b0;
        end else if (p.tick) begin
            picked <= next_picked;
        end
    end

    assign p.picked = picked;

    a_hyst_hold: assert property (@(posedge clk) disable iff (!rstn)
        p.tick && picked && !p.under && over_hold |=> picked) // [RULE8]
        else $error("pick-up released inside the hysteresis band");
    a_pick_hold: assert property (@(posedge clk) disable iff (!rstn)
        !p.tick |=> picked == $past(picked)) // [RULE7]
        else $error("pick-up changed outside a program cycle tick");
endmodule

// ==== dv/pps_front.sv ====
// Purpose: measurement front end and blocking matrix model
// Assumes: program cycle of four clocks
// Notes:   requests land one clock later, well before the next tick
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_front (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic [`PPS_MW-1:0]   lvl,
    input  wire logic                 blk_req,
    input  wire logic [`PPS_FT_W-1:0] ft_req,
    output logic                      cycle_tick,
    output logic      [`PPS_MW-1:0]   meas,
    output logic                      blk_in,
    output logic      [`PPS_FT_W-1:0] fault_type
);
    logic [1:0] cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt        <= 2'h0;
            cycle_tick <= 1'b0;
            meas       <= 16'h0000;
            blk_in     <= 1'b0;
            fault_type <= 3'h0;
        end else begin
            cnt        <= cnt + 2'h1;
            cycle_tick <= (cnt == 2'h3);
            meas       <= lvl;
            // blocking is settled three clocks before the tick
            blk_in     <= blk_req;
            fault_type <= ft_req;
        end
    end
endmodule

// ==== dv/pps_stage_tb.sv ====
// Purpose: self-checking bench of the pick-up stage
// Assumes: pick level 0x0100, instant trip, over mode
// Notes:   table of stage steps, then register and input tests
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_stage_tb;
    typedef struct packed {
        logic [15:0] m;
        logic        b;
        logic [4:0]  e;
    } pps_row_t;
    logic        clk, rstn, wr, rd, cycle_tick, blk_in, blk_req, li_phase_rot;
    logic        li_reset_latch, li_reset_fault, start, blocked, trip, irq;
    logic        release_evt, blk_event, trip_latched, latch_clear, rec_run;
    logic        led_close, led_open, phase_acb;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [15:0] meas, lvl;
    logic [2:0]  fault_type, ft_req, dev_mode;
    logic [9:0]  obj_closed, obj_open;
    int          mismatches, checks_done, cyc;
    pps_row_t    rows [8];

    pps_front fe (.clk, .rstn, .lvl, .blk_req, .ft_req, .cycle_tick, .meas,
                  .blk_in, .fault_type);
    pps_stage dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .cycle_tick,
                   .meas, .blk_in, .fault_type, .obj_closed, .obj_open,
                   .li_reset_latch, .li_reset_fault, .li_phase_rot, .start,
                   .blocked, .trip, .release_evt, .blk_event, .trip_latched,
                   .latch_clear, .led_close, .led_open, .phase_acb,
                   .dev_mode, .rec_run, .irq);

    task automatic chk_out(input logic [4:0] got, input logic [4:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t outputs %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk_reg(rdata, exp);
    endtask
    // a new level is taken at one tick and judged at the next
    task automatic step(input logic [15:0] m, input logic b);
        @(posedge clk iff cycle_tick);
        lvl     <= m;
        blk_req <= b;
        @(posedge clk iff cycle_tick);
        @(posedge clk);
        #1;
    endtask
    task automatic lag;
        @(posedge clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        {rstn, wr, rd, addr, wdata, lvl, blk_req} = '0;
        {li_reset_latch, li_reset_fault, li_phase_rot, obj_open} = '0;
        {mismatches, checks_done, cyc} = '0;
        ft_req = 3'h5;
        obj_closed = 10'h001;
        rows = '{'{16'h0101, 1'b0, 5'b10100}, '{16'h00f9, 1'b0, 5'b10100},
                 '{16'h00f8, 1'b0, 5'b00010}, '{16'h0100, 1'b0, 5'b00000},
                 '{16'h0200, 1'b1, 5'b01001}, '{16'h0200, 1'b0, 5'b10100},
                 '{16'h0200, 1'b1, 5'b01011}, '{16'h0000, 1'b0, 5'b00000}};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(`PPS_ADDR_CFG, 32'h0000_0080);
        rd_chk(`PPS_ADDR_MODE, 32'h0);
        rd_chk(`PPS_ADDR_PICK, 32'h0000_0100);
        rd_chk(`PPS_ADDR_IRQ_MSK, 32'h0);
        rd_chk(8'h2c, 32'h0);
        chk_out({led_close, led_open, rec_run, phase_acb, |dev_mode}, 5'h10);
        foreach (rows[i]) begin
            step(rows[i].m, rows[i].b);
            chk_out({start, blocked, trip, release_evt, blk_event}, rows[i].e);
        end
        rd_chk(`PPS_ADDR_EVT_INFO, 32'h0005_0200);
        wr_reg(`PPS_ADDR_IRQ_MSK, 32'h7);
        rd_chk(`PPS_ADDR_IRQ_ST, 32'h7);
        chk_out({irq, 4'h0}, 5'h10);
        wr_reg(`PPS_ADDR_IRQ_ST, 32'h7);
        lag();
        chk_out({irq, 4'h0}, 5'h00);
        wr_reg(`PPS_ADDR_CMD, 32'h1);
        chk_out({latch_clear, trip_latched, 3'h0}, 5'h10);
        rd_chk(`PPS_ADDR_CMD, 32'h0);
        wr_reg(`PPS_ADDR_IRQ_MSK, 32'h0);
        step(16'h0200, 1'b0);
        rd_chk(`PPS_ADDR_STAT, 32'h0000_00eb);
        rd_chk(`PPS_ADDR_FAULT, 32'h0000_0200);
        rd_chk(`PPS_ADDR_IRQ_ST, 32'h5);
        chk_out({irq, 4'h0}, 5'h00);
        wr_reg(`PPS_ADDR_IRQ_MSK, 32'h4);
        lag();
        chk_out({irq, 4'h0}, 5'h10);
        @(posedge clk);
        {li_reset_latch, li_reset_fault} <= 2'b11;
        @(posedge clk);
        {li_reset_latch, li_reset_fault} <= 2'b00;
        #1;
        chk_out({latch_clear, trip_latched, 3'h0}, 5'h10);
        rd_chk(`PPS_ADDR_STAT, 32'h0000_002b);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            obj_closed <= 10'h001 << i;
            obj_open   <= ~(10'h001 << i);
            wr_reg(`PPS_ADDR_CFG, 32'h80 | i);
            lag();
            chk_out({led_close, led_open, 3'h0}, 5'h10);
        end
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            li_phase_rot <= v[0];
            lag();
            chk_out({phase_acb, 4'h0}, {v[0], 4'h0});
        end
        wr_reg(`PPS_ADDR_CFG, 32'h0b0);
        lag();
        chk_out({rec_run, phase_acb, 3'h0}, 5'h18);
        wr_reg(`PPS_ADDR_MODE, 32'h1);
        rd_chk(`PPS_ADDR_MODE, 32'h0);
        wr_reg(`PPS_ADDR_CFG, 32'h180);
        for (int m = 4; m >= 0; m--) begin
            wr_reg(`PPS_ADDR_MODE, m);
            rd_chk(`PPS_ADDR_MODE, m);
            chk_out({2'h0, dev_mode}, m[4:0]);
        end
        // under mode: picks below the level, lets go at 100/97 of it
        wr_reg(`PPS_ADDR_CFG, 32'h0c0);
        step(16'h0080, 1'b0);
        chk_out({start, blocked, trip, release_evt, blk_event}, 5'b10100);
        step(16'h0107, 1'b0);
        chk_out({start, blocked, trip, release_evt, blk_event}, 5'b10100);
        step(16'h0108, 1'b0);
        chk_out({start, blocked, trip, release_evt, blk_event}, 5'b00010);
        final_report();
    end
endmodule
